//--- pdec_pkg.sv
package pdec_pkg;
	// function pin codes
	localparam logic [3:0] CODE_PAR = 4'h0;
	localparam logic [3:0] CODE_SER = 4'h1;
	localparam logic [3:0] CODE_FTW_FULL = 4'h2;
	localparam logic [3:0] CODE_FTW_SWAP = 4'h3;
	localparam logic [3:0] CODE_POW_AMP = 4'h4;
	localparam logic [3:0] CODE_AMP_POW = 4'h5;
	localparam logic [3:0] CODE_HI_FIRST = 4'h6;
	localparam logic [3:0] CODE_HI_LAST = 4'h9;
	localparam logic [3:0] CODE_LO_FIRST = 4'hA;
	localparam logic [3:0] CODE_LO_LAST = 4'hD;
	// low-byte slot order inside the partial-tuning codes
	localparam logic [1:0] SLOT_AMP_HI = 2'h0;
	localparam logic [1:0] SLOT_POW_HI = 2'h1;
	localparam logic [1:0] SLOT_AMP_LO = 2'h2;
	localparam logic [1:0] SLOT_POW_LO = 2'h3;
	// widths and port field positions
	localparam int PORT_W = 32;
	localparam int FTW_W = 32;
	localparam int POW_W = 16;
	localparam int AMP_W = 12;
	localparam int BYTE_W = 8;
	localparam int HALF = 16;
	localparam int ADDR_LSB = 8;
	localparam int CTL_WR = 0;
	localparam int CTL_RD = 1;
	localparam int CTL_W16 = 2;
	localparam logic [31:0] OE_W16 = 32'hFFFF0000;
	localparam logic [31:0] OE_W8 = 32'h00FF0000;
	// serial pin positions in the low byte
	localparam int SER_CS = 0;
	localparam int SER_SCLK = 1;
	localparam int SER_SDIO = 2;
	localparam int SER_SDO = 3;
	localparam int SER_SYNC = 4;
	// port sample divider: 1/16 of core_clk
	localparam int SAMPLE_DIV = 16;
	localparam logic [3:0] DIV_LAST = 4'(SAMPLE_DIV - 1);
	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_CONTROL_FUNCTION_REGISTER_ONE = 6'h00;
	localparam logic [5:0] IDX_CONTROL_FUNCTION_REGISTER_TWO = 6'h01;
	localparam logic [5:0] IDX_STAT = 6'h02;
	localparam logic [5:0] IDX_FTW = 6'h03;
	localparam logic [5:0] IDX_PA = 6'h04;
	localparam int CONTROL_FUNCTION_REGISTER_ONE_STREAM = 17;
	localparam int CONTROL_FUNCTION_REGISTER_ONE_ASE = 8;
	localparam int CONTROL_FUNCTION_REGISTER_TWO_MATCH = 15;
	localparam logic [31:0] CONTROL_FUNCTION_REGISTER_ONE_RST = 32'h00000000;
	localparam logic [31:0] CONTROL_FUNCTION_REGISTER_TWO_RST = 32'h00000000;
	localparam logic [11:0] AMP_FULL = 12'hFFF;
	localparam int FIFO_DEPTH = 4;
	// decoded port mode, one-hot
	typedef enum logic [3:0] {
		MODE_IDLE = 4'b0001,
		MODE_PAR = 4'b0010,
		MODE_SER = 4'b0100,
		MODE_DIR = 4'b1000
	} pdec_mode_t;
	// one synthesizer parameter set
	typedef struct packed {
		logic [31:0] frequency_tuning_word;
		logic [15:0] phase_offset_word;
		logic [11:0] amplitude_word;
	} pdec_word_t;
endpackage : pdec_pkg

//--- pdec_parallel_port_function_decoder.sv
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps

// small synchronous fifo, ready/valid both sides
module pdec_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 4,
	parameter int AW = $clog2(DEPTH)
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	logic [W-1:0] mem [DEPTH]; // storage
	logic [AW-1:0] wr_reg, wr_next; // write pointer
	logic [AW-1:0] rd_reg, rd_next; // read pointer
	logic [AW:0] cnt_reg, cnt_next; // fill level
	logic push, pop;

	assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
	assign out_valid = (cnt_reg != '0);
	assign out_data = mem[rd_reg];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// pointer arithmetic, wraps at depth
	always_comb begin
		wr_next = wr_reg;
		rd_next = rd_reg;
		if (push) begin
			wr_next = (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
		end
		if (pop) begin
			rd_next = (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
		end
		cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
	end

	// registers only
	always_ff @(posedge core_clk) begin
		if (rst) begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
		end else begin
			wr_reg <= wr_next;
			rd_reg <= rd_next;
			cnt_reg <= cnt_next;
		end
		if (push) begin
			mem[wr_reg] <= in_data;
		end
	end
endmodule : pdec_fifo

// How it works
// - four function pins pick port layout
// - code 0000: data, address, control fields
// - control bits: read/write, 16 or 8 bits
// - address picks register, data carries contents
// - code 0001: low byte carries serial signals
// - code 0010: full tuning word, msb aligned
// - code 0011: tuning word bytes swapped halves
// - code 0100: phase high, amplitude low
// - code 0101: amplitude high, phase low
// - codes 0110-1001: tuning 31:8 plus byte
// - codes 1010-1101: tuning 23:0 plus byte
// - amplitude keeps only twelve low bits
// - amplitude applies only with scaling enable
// - port bit 31 msb, bit 0 lsb
// - streaming skips update strobe, else wait
// - port sampled at core_clk over sixteen, serial pins every cycle
// - matched latency aligns all three parameters
module pdec_parallel_port_function_decoder import pdec_pkg::*; (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [3:0] func_sel, // function pins
	input wire logic [31:0] port_in, // parallel port level
	output logic [31:0] port_out, // parallel port drive
	output logic [31:0] port_oe, // high where we drive
	input wire logic io_update, // transfer strobe
	output logic ser_cs_n, // serial chip select
	output logic ser_sclk, // serial clock
	output logic ser_sdio_in, // serial data in
	output logic ser_sync_abort, // serial abort
	input wire logic ser_sdo, // serial engine data out
	input wire logic ser_sdio_out, // serial engine sdio drive
	input wire logic ser_sdio_oe, // serial engine sdio enable
	input wire logic core_ready, // core accepts a set
	output logic [31:0] core_ftw, // to synthesizer core
	output logic [15:0] core_pow,
	output logic [11:0] core_amp,
	output logic core_load, // one-cycle apply pulse
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata
);
	logic [3:0] div_reg, div_next; // sample divider
	logic sample_en; // one cycle in sixteen
	pdec_mode_t mode; // decoded from pins
	logic [15:0] pmem [256]; // programming register space
	logic [2:0] ctl; // parallel control field
	logic [7:0] paddr; // parallel address field
	pdec_word_t hold_reg, hold_next; // holding registers
	pdec_word_t snap_reg, snap_next; // set waiting for fifo
	logic pend_reg, pend_next;
	logic req; // transfer request
	logic [1:0] slot; // partial-code slot
	logic [31:0] pout_reg, pout_next;
	logic [31:0] poe_reg, poe_next;
	logic [4:0] ser_reg, ser_next; // captured serial pins
	logic [31:0] control_function_register_one_reg, control_function_register_one_next;
	logic [31:0] control_function_register_two_reg, control_function_register_two_next;
	logic [31:0] rdata_reg, rdata_next;
	logic f_in_ready, f_out_valid, pop;
	pdec_word_t head; // fifo head
	pdec_word_t stg_reg, stg_next; // pipeline stage
	logic stg_v_reg, stg_v_next;
	pdec_word_t out_reg, out_next; // core parameters
	logic load_reg, load_next;
	logic match, stream;

	assign sample_en = (div_reg == DIV_LAST);
	assign ctl = port_in[CTL_W16:CTL_WR];
	assign paddr = port_in[ADDR_LSB +: BYTE_W];
	assign match = control_function_register_two_reg[CONTROL_FUNCTION_REGISTER_TWO_MATCH];
	assign stream = control_function_register_one_reg[CONTROL_FUNCTION_REGISTER_ONE_STREAM];
	assign slot = 2'(func_sel - ((func_sel >= CODE_LO_FIRST) ? CODE_LO_FIRST : CODE_HI_FIRST));
	assign req = stream ? (sample_en && mode == MODE_DIR) : io_update;
	assign pop = f_out_valid && core_ready;

	// mode decode from function pins
	always_comb begin
		if (func_sel == CODE_PAR) begin
			mode = MODE_PAR;
		end else if (func_sel == CODE_SER) begin
			mode = MODE_SER;
		end else if (func_sel <= CODE_LO_LAST) begin
			mode = MODE_DIR;
		end else begin
			mode = MODE_IDLE;
		end
	end

	// direct modes: route port bits into holding registers
	always_comb begin
		hold_next = hold_reg;
		if (sample_en && mode == MODE_DIR) begin
			case (func_sel)
				CODE_FTW_FULL: hold_next.frequency_tuning_word = port_in;
				CODE_FTW_SWAP: begin
					hold_next.frequency_tuning_word = {port_in[HALF-1:0], port_in[PORT_W-1:HALF]};
				end
				CODE_POW_AMP: begin
					hold_next.phase_offset_word = port_in[HALF +: POW_W];
					hold_next.amplitude_word = port_in[AMP_W-1:0];
				end
				CODE_AMP_POW: begin
					hold_next.amplitude_word = port_in[HALF +: AMP_W];
					hold_next.phase_offset_word = port_in[POW_W-1:0];
				end
				default: begin
					if (func_sel <= CODE_HI_LAST) begin
						hold_next.frequency_tuning_word[FTW_W-1:BYTE_W] = port_in[PORT_W-1:BYTE_W];
					end else begin
						hold_next.frequency_tuning_word[FTW_W-BYTE_W-1:0] = port_in[PORT_W-1:BYTE_W];
					end
					case (slot)
						// upper amplitude nibble only, bits above are dropped
						SLOT_AMP_HI: hold_next.amplitude_word[AMP_W-1:BYTE_W] = port_in[AMP_W-BYTE_W-1:0];
						SLOT_POW_HI: hold_next.phase_offset_word[POW_W-1:BYTE_W] = port_in[BYTE_W-1:0];
						SLOT_AMP_LO: hold_next.amplitude_word[BYTE_W-1:0] = port_in[BYTE_W-1:0];
						SLOT_POW_LO: hold_next.phase_offset_word[BYTE_W-1:0] = port_in[BYTE_W-1:0];
						default: hold_next = hold_reg;
					endcase
				end
			endcase
		end
	end

	// snapshot and pending flag; new request wins over acceptance
	always_comb begin
		snap_next = snap_reg;
		pend_next = pend_reg;
		if (pend_reg && f_in_ready) begin
			pend_next = 1'b0;
		end
		if (req) begin
			snap_next = hold_next;
			pend_next = 1'b1;
		end
	end

	// port drive: parallel read data and serial outputs
	always_comb begin
		pout_next = pout_reg;
		poe_next = poe_reg;
		ser_next = ser_reg;
		if (mode == MODE_SER) begin
			ser_next = port_in[SER_SYNC:SER_CS];
			pout_next = '0;
			poe_next = '0;
			pout_next[SER_SDO] = ser_sdo;
			poe_next[SER_SDO] = 1'b1;
			pout_next[SER_SDIO] = ser_sdio_out;
			poe_next[SER_SDIO] = ser_sdio_oe;
		end else if (mode != MODE_PAR) begin
			poe_next = '0; // nothing driven outside programming
		end else if (sample_en) begin
			poe_next = '0;
			if (ctl[CTL_RD]) begin
				// read data held until the next port sample
				pout_next = '0;
				if (ctl[CTL_W16]) begin
					pout_next[PORT_W-1:HALF] = pmem[paddr];
					poe_next = OE_W16;
				end else begin
					pout_next[HALF +: BYTE_W] = pmem[paddr][BYTE_W-1:0];
					poe_next = OE_W8;
				end
			end
		end
	end

	// control registers and read mux
	always_comb begin
		control_function_register_one_next = control_function_register_one_reg;
		control_function_register_two_next = control_function_register_two_reg;
		rdata_next = '0; // unmapped reads zero
		if (reg_wr) begin
			case (reg_addr)
				{IDX_CONTROL_FUNCTION_REGISTER_ONE, 2'b00}: control_function_register_one_next = reg_wdata;
				{IDX_CONTROL_FUNCTION_REGISTER_TWO, 2'b00}: control_function_register_two_next = reg_wdata;
				default: control_function_register_one_next = control_function_register_one_reg;
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				{IDX_CONTROL_FUNCTION_REGISTER_ONE, 2'b00}: rdata_next = control_function_register_one_reg;
				{IDX_CONTROL_FUNCTION_REGISTER_TWO, 2'b00}: rdata_next = control_function_register_two_reg;
				{IDX_STAT, 2'b00}: begin
					rdata_next = {22'h0, func_sel, mode, f_out_valid, f_in_ready};
				end
				{IDX_FTW, 2'b00}: rdata_next = out_reg.frequency_tuning_word;
				{IDX_PA, 2'b00}: rdata_next = {4'h0, core_amp, out_reg.phase_offset_word};
				default: rdata_next = '0;
			endcase
		end
	end

	// fifo between port side and core
	pdec_fifo #(.W($bits(pdec_word_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
		.core_clk(core_clk),
		.rst(rst),
		.in_valid(pend_reg),
		.in_ready(f_in_ready),
		.in_data(snap_reg),
		.out_valid(f_out_valid),
		.out_ready(core_ready),
		.out_data(head)
	);

	// core side; unmatched phase/amplitude land a cycle before frequency
	always_comb begin
		stg_next = stg_reg;
		stg_v_next = pop;
		out_next = out_reg;
		load_next = 1'b0;
		if (pop) begin
			stg_next = head;
			if (!match) begin
				out_next.phase_offset_word = head.phase_offset_word;
				out_next.amplitude_word = head.amplitude_word;
				load_next = 1'b1;
			end
		end
		if (stg_v_reg) begin
			out_next.frequency_tuning_word = stg_reg.frequency_tuning_word;
			load_next = 1'b1;
			if (match) begin
				out_next.phase_offset_word = stg_reg.phase_offset_word;
				out_next.amplitude_word = stg_reg.amplitude_word;
			end
		end
	end

	// divider next value
	always_comb begin
		div_next = (div_reg == DIV_LAST) ? '0 : div_reg + 1'b1;
	end

	// all state registers except the programming register space
	always_ff @(posedge core_clk) begin
		if (rst) begin
			div_reg <= '0;
			hold_reg <= '0;
			snap_reg <= '0;
			pend_reg <= 1'b0;
			pout_reg <= '0;
			poe_reg <= '0;
			ser_reg <= 5'h01; // chip select idle high
			control_function_register_one_reg <= CONTROL_FUNCTION_REGISTER_ONE_RST;
			control_function_register_two_reg <= CONTROL_FUNCTION_REGISTER_TWO_RST;
			rdata_reg <= '0;
			stg_reg <= '0;
			stg_v_reg <= 1'b0;
			out_reg <= '0;
			load_reg <= 1'b0;
		end else begin
			div_reg <= div_next;
			hold_reg <= hold_next;
			snap_reg <= snap_next;
			pend_reg <= pend_next;
			pout_reg <= pout_next;
			poe_reg <= poe_next;
			ser_reg <= ser_next;
			control_function_register_one_reg <= control_function_register_one_next;
			control_function_register_two_reg <= control_function_register_two_next;
			rdata_reg <= rdata_next;
			stg_reg <= stg_next;
			stg_v_reg <= stg_v_next;
			out_reg <= out_next;
			load_reg <= load_next;
		end
	end

	// programming register space, 8 or 16 bit writes
	always_ff @(posedge core_clk) begin
		if (sample_en && mode == MODE_PAR && ctl[CTL_WR]) begin
			if (ctl[CTL_W16]) begin
				pmem[paddr] <= port_in[PORT_W-1:HALF];
			end else begin
				pmem[paddr][BYTE_W-1:0] <= port_in[HALF +: BYTE_W];
			end
		end
	end

	assign port_out = pout_reg;
	assign port_oe = poe_reg;
	assign {ser_sync_abort, ser_sdio_in, ser_sclk, ser_cs_n} =
		{ser_reg[SER_SYNC], ser_reg[SER_SDIO], ser_reg[SER_SCLK], ser_reg[SER_CS]};
	assign core_ftw = out_reg.frequency_tuning_word;
	assign core_pow = out_reg.phase_offset_word;
	assign core_amp = control_function_register_one_reg[CONTROL_FUNCTION_REGISTER_ONE_ASE] ? out_reg.amplitude_word : AMP_FULL;
	assign core_load = load_reg;
	assign reg_rdata = rdata_reg;

	// checks
	property p_div;
		@(posedge core_clk) disable iff (rst) sample_en |=> !sample_en [*8] ##8 sample_en;
	endproperty
	a_div: assert property (p_div) else $error("sample rate wrong");
	property p_full;
		@(posedge core_clk) disable iff (rst)
		sample_en && func_sel == CODE_FTW_FULL |=> hold_reg.frequency_tuning_word == $past(port_in);
	endproperty
	a_full: assert property (p_full) else $error("full tuning load wrong");
	property p_swap;
		@(posedge core_clk) disable iff (rst) sample_en && func_sel == CODE_FTW_SWAP
		|=> hold_reg.frequency_tuning_word == {$past(port_in[15:0]), $past(port_in[31:16])};
	endproperty
	a_swap: assert property (p_swap) else $error("swapped tuning load wrong");
	property p_pa;
		@(posedge core_clk) disable iff (rst) sample_en && func_sel == CODE_POW_AMP
		|=> hold_reg.amplitude_word == $past(port_in[11:0]) && hold_reg.phase_offset_word == $past(port_in[31:16]);
	endproperty
	a_pa: assert property (p_pa) else $error("phase/amp load wrong");
	property p_ap;
		@(posedge core_clk) disable iff (rst) sample_en && func_sel == CODE_AMP_POW
		|=> hold_reg.amplitude_word == $past(port_in[27:16]) && hold_reg.phase_offset_word == $past(port_in[15:0]);
	endproperty
	a_ap: assert property (p_ap) else $error("amp/phase load wrong");
	property p_unused;
		@(posedge core_clk) disable iff (rst) func_sel > CODE_LO_LAST |=> $stable(hold_reg);
	endproperty
	a_unused: assert property (p_unused) else $error("unused code changed state");
	property p_nostream;
		@(posedge core_clk) disable iff (rst)
		!stream && !io_update && !pend_reg |=> !pend_reg;
	endproperty
	a_nostream: assert property (p_nostream) else $error("transfer without strobe");
	property p_match;
		@(posedge core_clk) disable iff (rst) pop && match && $stable(match)
		|=> ##1 core_pow == $past(head.phase_offset_word, 2) && core_ftw == $past(head.frequency_tuning_word, 2) && core_load;
	endproperty
	a_match: assert property (p_match) else $error("latency not matched");
	property p_rd_oe;
		@(posedge core_clk) disable iff (rst) sample_en && mode == MODE_PAR && ctl[CTL_RD]
		|=> port_oe == (($past(ctl[CTL_W16])) ? OE_W16 : OE_W8);
	endproperty
	a_rd_oe: assert property (p_rd_oe) else $error("read lanes wrong");
	property p_ase;
		@(posedge core_clk) disable iff (rst) !control_function_register_one_reg[CONTROL_FUNCTION_REGISTER_ONE_ASE] |-> core_amp == AMP_FULL;
	endproperty
	a_ase: assert property (p_ase) else $error("amplitude used while disabled");
	c_full: cover property (@(posedge core_clk) disable iff (rst) !f_in_ready && pend_reg);
	c_load: cover property (@(posedge core_clk) disable iff (rst) core_load && match);
	c_read: cover property (@(posedge core_clk) disable iff (rst) poe_reg == OE_W16);
endmodule : pdec_parallel_port_function_decoder

//--- pdec_ctrl_model.sv
`timescale 1ns/1ps

// external controller on the port: code pins plus its share of the port
module pdec_ctrl_model (
	input wire logic [3:0] c_fs, // code the controller selects
	input wire logic [31:0] c_val, // controller drive value
	input wire logic [31:0] c_oe, // high where the controller drives
	input wire logic [31:0] port_out, // device drive value
	input wire logic [31:0] port_oe, // device enables
	output logic [3:0] func_sel,
	output logic [31:0] port_in
);
	// code pins are always driven from this side
	assign func_sel = c_fs;
	// device wins where it drives; an undriven pin shows the inverse so stale data never matches
	assign port_in = (port_oe & port_out) | (~port_oe & c_oe & c_val)
		| (~port_oe & ~c_oe & ~c_val);
endmodule : pdec_ctrl_model

//--- pdec_parallel_port_function_decoder_bench.sv
`timescale 1ns/1ps

// self-checking bench for the port function decoder
module pdec_parallel_port_function_decoder_bench import pdec_pkg::*; ;
	logic core_clk = 1'b0; // 200 MHz
	logic rst = 1'b1;
	logic [3:0] c_fs = 4'hE; // start on an unused code
	logic [31:0] c_val = 32'h00000000;
	logic [31:0] c_oe = 32'hFFFFFFFF;
	logic io_update = 1'b0;
	logic ser_sdo = 1'b0;
	logic ser_sdio_out = 1'b0;
	logic ser_sdio_oe = 1'b0;
	logic core_ready = 1'b1; // core side, stalled in the fifo test
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h00000000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [3:0] func_sel;
	logic [31:0] port_in, port_out, port_oe, core_ftw, reg_rdata, w;
	logic [15:0] core_pow;
	logic [11:0] core_amp;
	logic ser_cs_n, ser_sclk, ser_sdio_in, ser_sync_abort, core_load;
	logic [31:0] eftw = 32'h00000000; // expected parameter set
	logic [15:0] epow = 16'h0000;
	logic [11:0] eamp = 12'h000;
	logic mchk = 1'b0; // watch every core load
	int ph = 0; // edges since reset release, keeps us on the sample grid
	int n_loads = 0; // core load pulses seen, one per set when matched
	int miscompares = 0;
	int n_tests = 0;

	pdec_ctrl_model i_pdec_ctrl_model (.c_fs(c_fs), .c_val(c_val), .c_oe(c_oe),
		.port_out(port_out), .port_oe(port_oe), .func_sel(func_sel), .port_in(port_in));
	pdec_parallel_port_function_decoder i_pdec_parallel_port_function_decoder (
		.core_clk(core_clk), .rst(rst), .func_sel(func_sel), .port_in(port_in),
		.port_out(port_out), .port_oe(port_oe), .io_update(io_update),
		.ser_cs_n(ser_cs_n), .ser_sclk(ser_sclk), .ser_sdio_in(ser_sdio_in),
		.ser_sync_abort(ser_sync_abort), .ser_sdo(ser_sdo), .ser_sdio_out(ser_sdio_out),
		.ser_sdio_oe(ser_sdio_oe), .core_ready(core_ready), .core_ftw(core_ftw),
		.core_pow(core_pow), .core_amp(core_amp), .core_load(core_load),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata));

	always #2.5 core_clk = ~core_clk;
	// phase counter restarts with the device divider
	always @(posedge core_clk) ph <= rst ? 0 : ph + 1;

	// compare and count
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// one-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr

	// read strobe, data taken in the following cycle only
	task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 chk(nm, reg_rdata, e);
	endtask : rc

	// new port word mid-period so exactly one sample edge sees it whatever the phase
	task automatic drive(input logic [3:0] fs, input logic [31:0] v, input logic [31:0] oe);
		@(posedge core_clk);
		while (ph % 16 != 7) @(posedge core_clk);
		c_fs <= fs;
		c_val <= v;
		c_oe <= oe;
	endtask : drive

	task automatic wt(input int n);
		repeat (n) @(posedge core_clk);
	endtask : wt

	// whole period on the port, ending just before the next word
	task automatic pp(input logic [3:0] fs, input logic [31:0] v, input logic [31:0] oe);
		drive(fs, v, oe);
		wt(15);
		#1;
	endtask : pp

	// expected effect of one direct-mode sample
	function automatic void upd(input logic [3:0] fs, input logic [31:0] v);
		logic [1:0] slot;
		slot = 2'(fs - CODE_HI_FIRST);
		if (fs >= CODE_LO_FIRST) slot = 2'(fs - CODE_LO_FIRST);
		case (fs)
			CODE_FTW_FULL: eftw = v;
			CODE_FTW_SWAP: eftw = {v[15:0], v[31:16]};
			CODE_POW_AMP: begin
				epow = v[31:16];
				eamp = v[11:0];
			end
			CODE_AMP_POW: begin
				eamp = {v[27:24], v[23:16]};
				epow = v[15:0];
			end
			4'h6, 4'h7, 4'h8, 4'h9: eftw[31:8] = v[31:8];
			4'hA, 4'hB, 4'hC, 4'hD: eftw[23:0] = v[31:8];
			default: ; // unused codes leave everything alone
		endcase
		if (fs inside {[CODE_HI_FIRST:CODE_LO_LAST]}) begin
			case (slot)
				SLOT_AMP_HI: eamp[11:8] = v[3:0];
				SLOT_POW_HI: epow[15:8] = v[7:0];
				SLOT_AMP_LO: eamp[7:0] = v[7:0];
				default: epow[7:0] = v[7:0];
			endcase
		end
	endfunction : upd

	// matched latency: every load carries frequency and phase at once
	always @(posedge core_clk) begin
		if (core_load === 1'b1) begin
			n_loads++;
		end
		if (mchk && core_load === 1'b1) begin
			chk("load_ftw", core_ftw, eftw);
			chk("load_pow", core_pow, epow);
		end
	end

	// verdict in one place
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : finish_test

	// tests take about 480 cycles; cut a hang at about twelve times that
	initial begin
		#30000;
		miscompares++;
		finish_test();
	end

	// main sequence
	initial begin
		wt(4);
		chk("rst_oe", port_oe, 32'h00000000);
		chk("rst_cs", ser_cs_n, 1'b1);
		chk("rst_amp", core_amp, AMP_FULL);
		rst <= 1'b0;
		wr(8'h00, 32'h00020100); // streaming and amplitude scaling on
		wr(8'h04, 32'h00008000); // matched latency on
		rc("control_function_register_one", 8'h00, 32'h00020100);
		rc("control_function_register_two", 8'h04, 32'h00008000);
		wr(8'h40, 32'hFFFFFFFF); // unmapped place, must be dropped
		rc("unmapped", 8'h40, 32'h00000000);
		mchk = 1'b1;
		// every direct code and both unused codes
		for (int f = 2; f < 16; f++) begin
			w = 32'h5A3C96E1 ^ {8{4'(f)}};
			drive(4'(f), w, 32'hFFFFFFFF);
			wt(6);
			chk("ftw_hold", core_ftw, eftw);
			upd(4'(f), w);
			wt(9);
			#1 chk("ftw", core_ftw, eftw);
			chk("pow", core_pow, epow);
			chk("amp", core_amp, eamp);
		end
		wr(8'h00, 32'h00020000); // scaling off
		#1 chk("amp_off", core_amp, AMP_FULL);
		wr(8'h00, 32'h00000100); // streaming off, scaling on
		// holding registers wait for the strobe
		w = 32'hC0DE1234;
		pp(CODE_FTW_FULL, w, 32'hFFFFFFFF);
		chk("no_stream", core_ftw, eftw);
		upd(CODE_FTW_FULL, w);
		@(posedge core_clk);
		io_update <= 1'b1;
		@(posedge core_clk);
		io_update <= 1'b0;
		wt(8);
		chk("update", core_ftw, eftw);
		rc("stat_dir", 8'h08, {22'h0, CODE_FTW_FULL, MODE_DIR, 2'b01});
		// core stalls while strobes pile up, then drains
		@(posedge core_clk);
		core_ready <= 1'b0;
		io_update <= 1'b1;
		wt(6);
		io_update <= 1'b0;
		rc("fifo_full", 8'h08, {22'h0, CODE_FTW_FULL, MODE_DIR, 2'b10});
		@(posedge core_clk);
		core_ready <= 1'b1;
		wt(20);
		rc("fifo_empty", 8'h08, {22'h0, CODE_FTW_FULL, MODE_DIR, 2'b01});
		// unmatched latency: phase and amplitude land one cycle before frequency
		wr(8'h04, 32'h00000000);
		pp(CODE_FTW_FULL, 32'h13579BDF, 32'hFFFFFFFF);
		pp(CODE_POW_AMP, 32'h2468ACE0, 32'hFFFFFFFF);
		mchk = 1'b0;
		@(posedge core_clk);
		io_update <= 1'b1;
		@(posedge core_clk);
		io_update <= 1'b0;
		wt(2);
		#1 chk("lead_pow", core_pow, 16'h2468);
		chk("lead_load", core_load, 1'b1);
		chk("lag_ftw", core_ftw, eftw);
		upd(CODE_FTW_FULL, 32'h13579BDF);
		upd(CODE_POW_AMP, 32'h2468ACE0);
		wt(1);
		#1 chk("late_ftw", core_ftw, eftw);
		chk("lead_amp", core_amp, eamp);
		// register programming: 16-bit write, 8-bit low-byte write, two reads
		pp(CODE_PAR, 32'hBEEF0505, 32'hFFFFFFFF);
		pp(CODE_PAR, 32'h00420501, 32'hFFFFFFFF);
		pp(CODE_PAR, 32'h00000506, 32'h0000FFFF);
		chk("rd16", port_out[31:16], 16'hBE42);
		chk("oe16", port_oe, OE_W16);
		pp(CODE_PAR, 32'h00000502, 32'h0000FFFF);
		chk("rd8", port_out[23:16], 8'h42);
		chk("oe8", port_oe, OE_W8);
		// serial pins on the low byte, upper bits noise
		@(posedge core_clk);
		ser_sdo <= 1'b1;
		ser_sdio_out <= 1'b1;
		ser_sdio_oe <= 1'b1;
		pp(CODE_SER, 32'hABCDE012, 32'hFFFFFFF3);
		chk("cs", ser_cs_n, 1'b0);
		chk("sclk", ser_sclk, 1'b1);
		chk("sdio", ser_sdio_in, 1'b1);
		chk("sync", ser_sync_abort, 1'b1);
		chk("sdo", {port_oe[3:2], port_out[3:2]}, 4'hF);
		chk("ser_ftw", core_ftw, eftw);
		rc("stat_ser", 8'h08, {22'h0, CODE_SER, MODE_SER, 2'b01});
		// twelve streamed codes, one strobe, five drained sets, two unmatched pulses
		chk("loads", n_loads, 32'd20);
		finish_test();
	end
endmodule : pdec_parallel_port_function_decoder_bench
